// ==== hw/tofs_sequencer.sv ====
// Up/down time-of-flight measurement sequencer with Wishbone register access.
//
// Contract
// [RQ1] Stop mask is fixed point with five fraction bits, scaled by predivider.
// [RQ2] Start command begins upstream: oscillator on, then programmed settling wait.
// [RQ3] Comparator, reference and switches powered only during measurement.
// [RQ4] Upstream: transmit capacitor and opposite fire output grounded.
// [RQ5] Receive capacitor charged, then receive charge delay waited.
// [RQ6] Receive input routed to comparator; active fire output starts timing.
// [RQ7] Configured fire pulses on active output; comparator feeds stop.
// [RQ8] Stops accepted only after mask expiry; at most three per direction.
// [RQ9] At end power everything down, then set interrupt flag.
// [RQ10] After mains-period wait repeat sequence in opposite direction.
// [RQ11] Host reads first results during the wait before overwrite.
// [RQ12] Comparator offset from 4-bit two's complement field, bits 25 to 28.
// [RQ13] First wave mode adds detection offset up to plus or minus 35 mV.
// [RQ14] First wave mode applies its offset and first absolute mask.
// [RQ15] First wave width measured, then comparator offset returned to zero.
// [RQ16] Timed stops selected by wave counts relative to first wave.
// [RQ17] Half-wave of first timed stop is reference for width ratio.
// [RQ18] All three stops and their average computed; average in result four.
// [RQ19] Without first wave the offset stays applied; measurement ends by timeout.
// [RQ20] Host programs masks ascending, three cycles apart, unused ones zero.
// [RQ21] One control bit enables first wave mode, reinterpreting masks two, three.
// [RQ22] Host sets first relative count at least three, ascending, max 63.
// [RQ23] Timeout status bit separates timeout from normal completion.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module tofs_sequencer #(
  parameter int MAINS50_CYC = tofs_pkg::CLK_HZ / tofs_pkg::MAINS50_HZ,
  parameter int MAINS60_CYC = tofs_pkg::CLK_HZ / tofs_pkg::MAINS60_HZ
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              compIn,
  output tofs_pkg::tofs_afe_s    afe,
  output logic                   intFlag
);
  if (MAINS50_CYC < 1 || MAINS60_CYC < 1 || MAINS50_CYC > 24'hffffff || MAINS60_CYC > 24'hffffff) begin : g_chk
    $error("Mains period counts out of range.");
  end

  typedef struct packed {
    tofs_pkg::tofs_state_e st;
    logic [31:0]           ctrl;
    logic [31:0]           mask1;
    logic [31:0]           mask2;
    logic [31:0]           mask3;
    logic [15:0]           oscDly;
    logic [7:0]            rxDly;
    logic [7:0]            fireCnt;
    logic [23:0]           tmo;
    logic                  irqFlag;
    logic                  tmoFlag;
    logic                  dir;
    logic [2:0]            sy;
    logic                  lvl;
    logic                  lvlPrev;
    logic [27:0]           cnt;
    logic [23:0]           cycles;
    logic [7:0]            pulses;
    logic [7:0]            half;
    logic                  fireLvl;
    logic [1:0]            stopCnt;
    logic [2:0][23:0]      res;
    logic [23:0]           avg;
    logic [7:0]            ratio;
    logic [1:0]            fwPh;
    logic [23:0]           fwT0;
    logic [23:0]           fwW;
    logic [5:0]            waves;
    logic [23:0]           hwpT0;
    logic [23:0]           hwp;
    logic                  hwpDone;
    logic                  ack;
    logic [31:0]           dat;
    tofs_pkg::tofs_afe_s   afe;
  } tofs_core_s;

  tofs_core_s s_r;
  tofs_core_s s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic        fw;
  logic        rise;
  logic        fall;
  logic        fwEdge;
  logic        fwOpp;
  logic [28:0] elapsedFx;
  logic [18:0] maskNow;
  logic [5:0]  relNow;
  logic [27:0] mainsWait;
  logic [25:0] sum;
  logic [30:0] pwNum;
  logic [30:0] pwQ;
  logic        done;
  logic        timedOut;
  logic        startCmd;

  always_comb begin
    // [RQ21] first wave enable
    fw        = s_r.ctrl[tofs_pkg::CTRL_FW];
    rise      = s_r.lvl & ~s_r.lvlPrev;
    fall      = ~s_r.lvl & s_r.lvlPrev;
    fwEdge    = s_r.mask3[tofs_pkg::M3_EDGE] ? fall : rise;
    fwOpp     = s_r.mask3[tofs_pkg::M3_EDGE] ? rise : fall;
    // [RQ1] mask time scaling
    elapsedFx = {s_r.cycles, 5'h0} >> s_r.ctrl[tofs_pkg::CTRL_DIV +: 2];
    unique case (s_r.stopCnt)
      2'h0: maskNow = s_r.mask1[tofs_pkg::MASK_W-1:0];
      2'h1: maskNow = s_r.mask2[tofs_pkg::MASK_W-1:0];
      default: maskNow = s_r.mask3[tofs_pkg::MASK_W-1:0];
    endcase
    // [RQ16] relative wave select
    relNow    = s_r.mask2[s_r.stopCnt*tofs_pkg::REL_W +: tofs_pkg::REL_W];
    mainsWait = 28'((s_r.ctrl[tofs_pkg::CTRL_HZ60] ? MAINS60_CYC : MAINS50_CYC)
                * ((s_r.ctrl[tofs_pkg::CTRL_MULT +: 3] == 3'h0) ? 1 : int'(s_r.ctrl[tofs_pkg::CTRL_MULT +: 3])));
    sum       = 26'(s_r.res[0]) + 26'(s_r.res[1]) + 26'(s_r.res[2]);
    pwNum     = {s_r.fwW, 7'h0};
    pwQ       = (s_r.hwp == 24'h0) ? 31'h0 : pwNum / 31'(s_r.hwp);
    done      = (s_r.stopCnt == tofs_pkg::STOP_MAX) && (!fw || s_r.mask3[tofs_pkg::M3_DISPW] || s_r.hwpDone);
    timedOut  = s_r.cycles >= s_r.tmo;
    startCmd  = cyc_i & stb_i & we_i & ~s_r.ack & (adr_i == tofs_pkg::REG_CTRL) & sel_i[0]
                & dat_i[tofs_pkg::CTRL_START] & (s_r.st == tofs_pkg::ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.ack     = 1'b0;
    s_nxt.sy      = {s_r.sy[1:0], compIn};
    s_nxt.lvlPrev = s_r.lvl;
    if (s_r.sy[2] == s_r.sy[1]) begin
      s_nxt.lvl = s_r.sy[2];
    end
    if (cyc_i && stb_i && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      if (we_i) begin
        unique case (adr_i)
          tofs_pkg::REG_CTRL: s_nxt.ctrl = wmerge(s_r.ctrl, dat_i & ~32'h1, sel_i);
          tofs_pkg::REG_MASK1: s_nxt.mask1 = wmerge(s_r.mask1, dat_i, sel_i);
          tofs_pkg::REG_MASK2: s_nxt.mask2 = wmerge(s_r.mask2, dat_i, sel_i);
          tofs_pkg::REG_MASK3: s_nxt.mask3 = wmerge(s_r.mask3, dat_i, sel_i);
          tofs_pkg::REG_OSC: s_nxt.oscDly = 16'(wmerge(32'(s_r.oscDly), dat_i, sel_i));
          tofs_pkg::REG_FIRE: {s_nxt.fireCnt, s_nxt.rxDly} = 16'(wmerge({16'h0, s_r.fireCnt, s_r.rxDly}, dat_i, sel_i));
          tofs_pkg::REG_TMO: s_nxt.tmo = 24'(wmerge(32'(s_r.tmo), dat_i, sel_i));
          tofs_pkg::REG_STAT: begin
            if (sel_i[0] && dat_i[tofs_pkg::STAT_IRQ]) begin
              s_nxt.irqFlag = 1'b0;
            end
          end
          default: ;
        endcase
        s_nxt.dat = tofs_pkg::REG_RST;
      end else begin
        unique case (adr_i)
          tofs_pkg::REG_CTRL: s_nxt.dat = s_r.ctrl;
          tofs_pkg::REG_MASK1: s_nxt.dat = s_r.mask1;
          tofs_pkg::REG_MASK2: s_nxt.dat = s_r.mask2;
          tofs_pkg::REG_MASK3: s_nxt.dat = s_r.mask3;
          tofs_pkg::REG_OSC: s_nxt.dat = 32'(s_r.oscDly);
          tofs_pkg::REG_FIRE: s_nxt.dat = {16'h0, s_r.fireCnt, s_r.rxDly};
          tofs_pkg::REG_TMO: s_nxt.dat = 32'(s_r.tmo);
          // [RQ23] timeout status bit
          tofs_pkg::REG_STAT: s_nxt.dat = 32'({s_r.stopCnt, s_r.dir, s_r.tmoFlag, s_r.irqFlag,
                                               s_r.st != tofs_pkg::ST_IDLE});
          tofs_pkg::REG_RES1: s_nxt.dat = 32'(s_r.res[0]);
          tofs_pkg::REG_RES2: s_nxt.dat = 32'(s_r.res[1]);
          tofs_pkg::REG_RES3: s_nxt.dat = 32'(s_r.res[2]);
          tofs_pkg::REG_RES4: s_nxt.dat = 32'(s_r.avg);
          tofs_pkg::REG_PW: s_nxt.dat = 32'(s_r.ratio);
          default: s_nxt.dat = tofs_pkg::REG_RST;
        endcase
      end
    end
    unique case (s_r.st)
      tofs_pkg::ST_IDLE: begin
        // [RQ2] upstream start
        if (startCmd) begin
          s_nxt.st          = tofs_pkg::ST_OSC;
          s_nxt.dir         = 1'b0;
          s_nxt.cnt         = 28'h0;
          s_nxt.tmoFlag     = 1'b0;
          s_nxt.afe.hsOscEn = 1'b1;
        end
      end
      tofs_pkg::ST_OSC: begin
        s_nxt.cnt = s_r.cnt + 28'h1;
        if (s_r.cnt >= 28'(s_r.oscDly)) begin
          // [RQ3] power front end
          s_nxt.st              = tofs_pkg::ST_CHARGE;
          s_nxt.cnt             = 28'h0;
          s_nxt.afe.analogPwr   = 1'b1;
          // [RQ4] ground opposite side
          s_nxt.afe.txCapGnd    = 1'b1;
          s_nxt.afe.fireOppGnd  = 1'b1;
          // [RQ5] charge receive capacitor
          s_nxt.afe.rxCapCharge = 1'b1;
          s_nxt.afe.dirDown     = s_r.dir;
          // [RQ12] comparator offset trim
          s_nxt.afe.trim        = s_r.ctrl[tofs_pkg::CTRL_TRIM +: 4];
          // [RQ13] first wave offset
          s_nxt.afe.fwOffsetOn  = fw;
          s_nxt.afe.fwOffset    = s_r.mask3[tofs_pkg::M3_OFFS +: 5];
          s_nxt.afe.fwRngNeg    = s_r.mask3[tofs_pkg::M3_RNGNEG];
          s_nxt.afe.fwRngPos    = s_r.mask3[tofs_pkg::M3_RNGPOS];
        end
      end
      tofs_pkg::ST_CHARGE: begin
        s_nxt.cnt = s_r.cnt + 28'h1;
        // [RQ5] receive charge delay
        if (s_r.cnt >= 28'(s_r.rxDly)) begin
          s_nxt.st                = tofs_pkg::ST_MEAS;
          s_nxt.afe.rxCapCharge   = 1'b0;
          // [RQ6] route receive input
          s_nxt.afe.rxPathSel     = 1'b1;
          s_nxt.afe.startFromFire = 1'b1;
          s_nxt.cycles            = 24'h0;
          s_nxt.pulses            = 8'h0;
          s_nxt.half              = 8'h0;
          s_nxt.fireLvl           = s_r.fireCnt != 8'h0;
          s_nxt.stopCnt           = 2'h0;
          s_nxt.fwPh              = 2'h0;
          s_nxt.waves             = 6'h0;
          s_nxt.hwp               = 24'h0;
          s_nxt.hwpDone           = 1'b0;
        end
      end
      tofs_pkg::ST_MEAS: begin
        s_nxt.cycles = s_r.cycles + 24'h1;
        // [RQ7] fire pulse train
        if (s_r.pulses < s_r.fireCnt) begin
          s_nxt.half = s_r.half + 8'h1;
          if (s_r.half == 8'(tofs_pkg::FIRE_HALF_CYC - 1)) begin
            s_nxt.half    = 8'h0;
            s_nxt.fireLvl = ~s_r.fireLvl;
            if (s_r.fireLvl) begin
              s_nxt.pulses = s_r.pulses + 8'h1;
            end
            if (s_r.fireLvl && s_r.pulses + 8'h1 >= s_r.fireCnt) begin
              s_nxt.fireLvl = 1'b0;
            end
          end
        end
        if (!fw) begin
          // [RQ8] masked stop acceptance
          if (rise && s_r.stopCnt < tofs_pkg::STOP_MAX && elapsedFx >= 29'(maskNow)) begin
            s_nxt.res[s_r.stopCnt] = s_r.cycles;
            s_nxt.stopCnt          = s_r.stopCnt + 2'h1;
          end
        end else begin
          unique case (s_r.fwPh)
            2'h0: begin
              // [RQ14] first mask gates first wave
              if (fwEdge && elapsedFx >= 29'(s_r.mask1[tofs_pkg::MASK_W-1:0])) begin
                s_nxt.fwT0 = s_r.cycles;
                s_nxt.fwPh = 2'h1;
              end
            end
            2'h1: begin
              // [RQ15] width then offset release
              if (fwOpp) begin
                s_nxt.fwW            = s_r.cycles - s_r.fwT0;
                s_nxt.fwPh           = 2'h2;
                s_nxt.afe.fwOffsetOn = 1'b0;
              end
            end
            default: begin
              // [RQ16] relative wave stops
              if (rise && s_r.stopCnt < tofs_pkg::STOP_MAX) begin
                s_nxt.waves = s_r.waves + 6'h1;
                if (s_r.waves + 6'h1 == relNow) begin
                  s_nxt.res[s_r.stopCnt] = s_r.cycles;
                  s_nxt.stopCnt          = s_r.stopCnt + 2'h1;
                  if (s_r.stopCnt == 2'h0) begin
                    s_nxt.hwpT0 = s_r.cycles;
                  end
                end
              end
              // [RQ17] reference half wave
              if (fall && s_r.stopCnt != 2'h0 && !s_r.hwpDone) begin
                s_nxt.hwp     = s_r.cycles - s_r.hwpT0;
                s_nxt.hwpDone = 1'b1;
              end
            end
          endcase
        end
        // [RQ19] timeout ends measurement
        if (done || timedOut) begin
          // [RQ9] power down, flag
          s_nxt.afe.hsOscEn       = 1'b0;
          s_nxt.afe.analogPwr     = 1'b0;
          s_nxt.afe.txCapGnd      = 1'b0;
          s_nxt.afe.fireOppGnd    = 1'b0;
          s_nxt.afe.rxPathSel     = 1'b0;
          s_nxt.afe.startFromFire = 1'b0;
          s_nxt.fireLvl           = 1'b0;
          s_nxt.irqFlag           = 1'b1;
          s_nxt.tmoFlag           = ~done;
          // [RQ18] three stop average
          s_nxt.avg               = 24'(sum / 26'h3);
          // [RQ17] width ratio
          s_nxt.ratio             = (pwQ > 31'hff) ? 8'hff : 8'(pwQ);
          s_nxt.cnt               = 28'h0;
          s_nxt.st                = s_r.dir ? tofs_pkg::ST_IDLE : tofs_pkg::ST_MAINS;
        end
      end
      tofs_pkg::ST_MAINS: begin
        s_nxt.cnt = s_r.cnt + 28'h1;
        // [RQ10] opposite direction after wait
        if (s_r.cnt + 28'h1 >= mainsWait) begin
          s_nxt.st          = tofs_pkg::ST_OSC;
          s_nxt.dir         = 1'b1;
          s_nxt.cnt         = 28'h0;
          s_nxt.afe.hsOscEn = 1'b1;
        end
      end
    endcase
    s_nxt.afe.fireUp   = s_nxt.fireLvl & ~s_nxt.dir;
    s_nxt.afe.fireDown = s_nxt.fireLvl & s_nxt.dir;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dat_o   = s_r.dat;
  assign ack_o   = s_r.ack;
  assign afe     = s_r.afe;
  assign intFlag = s_r.irqFlag;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("Ack held longer than one cycle.");
  idle_off_a: assert property (s_r.st == tofs_pkg::ST_IDLE |-> !afe.analogPwr && !afe.hsOscEn) else $error("Powered in idle."); // [RQ3]
  power_order_a: assert property (afe.analogPwr |-> afe.hsOscEn) else $error("Front end powered without oscillator."); // [RQ3]
  up_ground_a: assert property (s_r.st == tofs_pkg::ST_MEAS && !s_r.dir |-> afe.txCapGnd && afe.fireOppGnd && !afe.fireDown) else $error("Up path not grounded."); // [RQ4]
  charge_hold_a: assert property (s_r.st == tofs_pkg::ST_OSC ##1 s_r.st == tofs_pkg::ST_CHARGE |-> (afe.rxCapCharge && !afe.rxPathSel) [*2]) else $error("Charge phase wrong."); // [RQ5]
  route_a: assert property (s_r.st == tofs_pkg::ST_MEAS |-> afe.rxPathSel && afe.startFromFire) else $error("Receive route missing."); // [RQ6]
  stop_mask_a: assert property (s_r.st == tofs_pkg::ST_MEAS && !fw && s_nxt.stopCnt != s_r.stopCnt |-> elapsedFx >= 29'(maskNow) && rise) else $error("Stop inside mask."); // [RQ8]
  irq_down_a: assert property ($rose(intFlag) |-> !afe.hsOscEn && !afe.analogPwr) else $error("Flag before power down."); // [RQ9]
  turn_dir_a: assert property ($past(s_r.st) == tofs_pkg::ST_MAINS && s_r.st == tofs_pkg::ST_OSC |-> s_r.dir && afe.hsOscEn) else $error("Second pass not reversed."); // [RQ10]
  trim_a: assert property (afe.analogPwr |-> afe.trim == s_r.ctrl[tofs_pkg::CTRL_TRIM +: 4]) else $error("Offset trim mismatch."); // [RQ12]
  fw_release_a: assert property ($fell(afe.fwOffsetOn) && afe.analogPwr |-> $past(s_r.fwPh) == 2'h1) else $error("Offset released early."); // [RQ15]
  avg_a: assert property ($rose(intFlag) |=> s_r.avg == 24'(sum / 26'h3)) else $error("Average wrong."); // [RQ18]
  tmo_flag_a: assert property ($rose(intFlag) |-> s_r.tmoFlag == (s_r.stopCnt != tofs_pkg::STOP_MAX || (fw && !s_r.mask3[tofs_pkg::M3_DISPW] && !s_r.hwpDone))) else $error("Timeout flag wrong."); // [RQ23]

  both_dirs_c: cover property (s_r.st == tofs_pkg::ST_MAINS ##[1:1000] $rose(intFlag));
  timeout_c: cover property ($rose(intFlag) && s_r.tmoFlag);
  fw_ratio_c: cover property ($rose(intFlag) && fw && s_r.hwpDone);
  three_stops_c: cover property (s_r.stopCnt == tofs_pkg::STOP_MAX && !fw);
endmodule // tofs_sequencer

// ==== hw/tofs_pkg.sv ====
// Constants and carrier types of the time-of-flight measurement sequencer.
package tofs_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int CLK_HZ        = CLK_MHZ * 1000000;
  localparam int MAINS50_HZ    = 50;
  localparam int MAINS60_HZ    = 60;
  localparam int FIRE_HALF_NS  = 250;
  localparam int FIRE_HALF_CYC = (FIRE_HALF_NS * CLK_MHZ) / 1000;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_MASK1 = 8'h04;
  localparam logic [7:0] REG_MASK2 = 8'h08;
  localparam logic [7:0] REG_MASK3 = 8'h0c;
  localparam logic [7:0] REG_OSC   = 8'h10;
  localparam logic [7:0] REG_FIRE  = 8'h14;
  localparam logic [7:0] REG_TMO   = 8'h18;
  localparam logic [7:0] REG_STAT  = 8'h1c;
  localparam logic [7:0] REG_RES1  = 8'h20;
  localparam logic [7:0] REG_RES2  = 8'h24;
  localparam logic [7:0] REG_RES3  = 8'h28;
  localparam logic [7:0] REG_RES4  = 8'h2c;
  localparam logic [7:0] REG_PW    = 8'h30;
  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_FW    = 1;
  localparam int CTRL_DIV   = 2;
  localparam int CTRL_HZ60  = 4;
  localparam int CTRL_MULT  = 5;
  localparam int CTRL_TRIM  = 25;
  localparam int M3_OFFS    = 0;
  localparam int M3_RNGNEG  = 5;
  localparam int M3_RNGPOS  = 6;
  localparam int M3_EDGE    = 7;
  localparam int M3_DISPW   = 8;
  localparam int STAT_IRQ   = 1;
  localparam int MASK_W     = 19;
  localparam int FX_BITS    = 5;
  localparam int REL_W      = 6;
  localparam int PW_FRAC    = 7;
  localparam logic [1:0] STOP_MAX = 2'h3;
  localparam logic [31:0] REG_RST = 32'h0;

  typedef enum {ST_IDLE, ST_OSC, ST_CHARGE, ST_MEAS, ST_MAINS} tofs_state_e;

  typedef struct packed {
    logic       hsOscEn;
    logic       analogPwr;
    logic       txCapGnd;
    logic       fireOppGnd;
    logic       rxCapCharge;
    logic       rxPathSel;
    logic       startFromFire;
    logic       fireUp;
    logic       fireDown;
    logic       dirDown;
    logic       fwOffsetOn;
    logic       fwRngNeg;
    logic       fwRngPos;
    logic [4:0] fwOffset;
    logic [3:0] trim;
  } tofs_afe_s;
endpackage

// ==== verification/tofs_echo_model.sv ====
// Receive-path model: answers a fire burst with a square echo.
`timescale 1ns/100ps
module tofs_echo_model #(
  parameter int DLY   = 62,
  parameter int HALF  = 10,
  parameter int WAVES = 15
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic fire,
  input  wire logic quiet,
  output logic      compIn
);
  // ----------------------------------------------------------------
  // Echo generator
  // ----------------------------------------------------------------
  int   cnt;
  logic run;
  logic fireD;

  // An empty pipe (quiet) keeps the comparator output low.
  always_ff @(posedge clk) begin
    fireD <= fire;
    if (reset) begin
      run    <= 1'b0;
      cnt    <= 0;
      compIn <= 1'b0;
    end else if (!run) begin
      compIn <= 1'b0;
      cnt    <= 0;
      run    <= fire && !fireD;
    end else begin
      cnt    <= cnt + 1;
      compIn <= !quiet && cnt >= DLY && ((cnt - DLY) / HALF) % 2 == 0;
      run    <= cnt < DLY + 2 * HALF * WAVES;
    end
  end
endmodule // tofs_echo_model

// ==== verification/tb.sv ====
// Self-checking testbench of the time-of-flight sequencer.
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic                clk, reset, cyc, stb, we, quiet, ack, intFlag, compIn, uD, fD;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         dw, dr, v, r1, r2, r3;
  tofs_pkg::tofs_afe_s afe;
  int                  errorCnt, totalChecks, nUp, nDn, n;

  tofs_sequencer #(.MAINS50_CYC(200), .MAINS60_CYC(166)) i_dut (
    .clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack), .compIn(compIn), .afe(afe),
    .intFlag(intFlag));
  tofs_echo_model i_echo (.clk(clk), .reset(reset), .fire(afe.fireUp | afe.fireDown),
    .quiet(quiet), .compIn(compIn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    uD <= afe.fireUp;
    fD <= afe.fireDown;
    if (afe.fireUp && !uD) nUp++;
    if (afe.fireDown && !fD) nDn++;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      errorCnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task finishTest;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dw  <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
    if (n == 20) begin
      errorCnt++;
      finishTest();
    end
    v = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task waitInt;
    for (n = 0; n < 3000 && intFlag !== 1'b1; n++) @(posedge clk);
    if (n == 3000) begin
      errorCnt++;
      finishTest();
    end
  endtask

  task meas(input logic [31:0] ctl, input logic [1:0] st, input logic to, input logic fw,
            input int lo, input int mains);
    int  u;
    int  d;
    time t0;
    u = nUp;
    d = nDn;
    bus(1'b1, tofs_pkg::REG_CTRL, ctl);
    repeat (3) @(posedge clk);
    chk({afe.hsOscEn, afe.analogPwr}, 2'b10);
    repeat (25) @(posedge clk);
    chk({afe.analogPwr, afe.txCapGnd, afe.fireOppGnd, afe.rxCapCharge, afe.dirDown}, 5'h1e);
    repeat (20) @(posedge clk);
    chk({afe.rxPathSel, afe.startFromFire, afe.fwOffsetOn}, {2'b11, fw});
    chk(afe.trim, ctl[28:25]);
    waitInt();
    t0 = $time;
    chk({afe.hsOscEn, afe.analogPwr, afe.fwOffsetOn}, {2'b00, to});
    chk(nUp - u, 2);
    chk(nDn - d, 0);
    bus(1'b0, tofs_pkg::REG_STAT, 32'h0);
    chk(v[5:1], {st, 1'b0, to, 1'b1});
    if (!to) begin
      bus(1'b0, tofs_pkg::REG_RES1, 32'h0);
      r1 = v;
      bus(1'b0, tofs_pkg::REG_RES2, 32'h0);
      r2 = v;
      bus(1'b0, tofs_pkg::REG_RES3, 32'h0);
      r3 = v;
      bus(1'b0, tofs_pkg::REG_RES4, 32'h0);
      chk(r1 >= lo && r1 <= lo + 10, 1);
      chk(r2 - r1, 20);
      chk(r3 - r2, 20);
      chk(v, (r1 + r2 + r3) / 3);
    end
    bus(1'b1, tofs_pkg::REG_STAT, 32'h2);
    @(posedge clk);
    chk(intFlag, 1'b0);
    for (n = 0; n < 3000 && afe.hsOscEn !== 1'b1; n++) @(posedge clk);
    chk(($time - t0) / 10 >= mains - 2 && ($time - t0) / 10 <= mains + 4, 1);
    waitInt();
    chk(nDn - d, 2);
    bus(1'b0, tofs_pkg::REG_STAT, 32'h0);
    chk(v[5:1], {st, 1'b1, to, 1'b1});
    bus(1'b1, tofs_pkg::REG_STAT, 32'h2);
  endtask

  initial begin
    reset = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'hf;
    dw = 32'h0;
    quiet = 1'b0;
    errorCnt = 0;
    totalChecks = 0;
    nUp = 0;
    nDn = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a <= 8'h34; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk(v, 32'h0);
    end
    bus(1'b1, tofs_pkg::REG_OSC, 32'd20);
    bus(1'b1, tofs_pkg::REG_FIRE, 32'h0214);
    bus(1'b1, tofs_pkg::REG_TMO, 32'd400);
    bus(1'b1, tofs_pkg::REG_MASK1, 32'd1600);
    bus(1'b1, tofs_pkg::REG_MASK2, 32'd1696);
    bus(1'b1, tofs_pkg::REG_MASK3, 32'd1792);
    meas(32'h25, 2'h3, 1'b0, 1'b0, 100, 200);
    bus(1'b1, tofs_pkg::REG_MASK2, 32'h5103);
    bus(1'b1, tofs_pkg::REG_MASK3, 32'ha);
    quiet <= 1'b1;
    meas(32'h12000033, 2'h0, 1'b1, 1'b1, 0, 166);
    quiet <= 1'b0;
    meas(32'h23, 2'h3, 1'b0, 1'b1, 120, 200);
    bus(1'b0, tofs_pkg::REG_PW, 32'h0);
    chk(v, 32'h80);
    finishTest();
  end
endmodule // tb
